// >>> verilog/pms_mode_switch.sv
// Our own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ns
`include "pms_map.svh"

// Function
// - Regulator runs P-only while chosen condition holds, else PI.
// - Disable bit set: automatic P-only switch never applies.
// - Selection bits pick torque, speed, acceleration or error pulses.
// - Torque mode: P-only when torque command exceeds threshold.
// - Speed mode: P-only when speed command exceeds threshold.
// - Acceleration mode: P-only when acceleration exceeds threshold.
// - Error mode: P-only when position error exceeds threshold.
// - Error mode acts only under position control.
// - Reset: bits zero, torque detection, threshold 200.
// - Power-loss bit 1 raises alarm after power returns; 0 none.
// - Servo-ready stays low while main power is off.
// - Active-low force input makes regulator P-only.
module pms_mode_switch
  import pms_pkg::*;
#(
  parameter int LEVEL_W = 16
)
(
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rst,
  // AXI4-Lite
  input  wire logic [7:0]           s_awaddr,
  input  wire logic                 s_awvalid,
  output logic                      s_awready,
  input  wire logic [31:0]          s_wdata,
  input  wire logic [3:0]           s_wstrb,
  input  wire logic                 s_wvalid,
  output logic                      s_wready,
  output logic [1:0]                s_bresp,
  output logic                      s_bvalid,
  input  wire logic                 s_bready,
  input  wire logic [7:0]           s_araddr,
  input  wire logic                 s_arvalid,
  output logic                      s_arready,
  output logic [31:0]               s_rdata,
  output logic [1:0]                s_rresp,
  output logic                      s_rvalid,
  input  wire logic                 s_rready,
  // Loop quantities
  input  wire pms_sample_type       sample,
  input  wire logic                 position_mode,
  input  wire logic                 force_proportional_in_n,
  // Power
  input  wire logic                 main_power_ok,
  // Outputs
  output logic                      p_mode,
  output logic                      servo_ready,
  output logic                      servo_alarm,
  output logic                      irq
);

  logic [15:0]        mode_config_word;
  logic [15:0]        switch_threshold_level;
  logic [2:0]         irq_stat;
  logic [2:0]         irq_mask;
  logic               auto_over;
  logic               auto_p;
  logic               power_q;
  logic [7:0]         settle_cnt;
  logic               wr_en;
  logic [7:0]         wr_addr;
  logic [31:0]        wr_data;
  logic [3:0]         wr_strb;
  logic [7:0]         rd_addr;
  logic [31:0]        rd_data;
  logic               rd_hit;
  logic               wr_hit;
  logic [2:0]         irq_event;
  pms_cfg_type        cfg;
  logic               next_p_mode;

  pms_axil_slave u_bus
  (
    .mclk      (mclk),
    .rst       (rst),
    .s_awaddr  (s_awaddr),
    .s_awvalid (s_awvalid),
    .s_awready (s_awready),
    .s_wdata   (s_wdata),
    .s_wstrb   (s_wstrb),
    .s_wvalid  (s_wvalid),
    .s_wready  (s_wready),
    .s_bresp   (s_bresp),
    .s_bvalid  (s_bvalid),
    .s_bready  (s_bready),
    .s_araddr  (s_araddr),
    .s_arvalid (s_arvalid),
    .s_arready (s_arready),
    .s_rdata   (s_rdata),
    .s_rresp   (s_rresp),
    .s_rvalid  (s_rvalid),
    .s_rready  (s_rready),
    .wr_en     (wr_en),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data),
    .wr_strb   (wr_strb),
    .rd_addr   (rd_addr),
    .rd_data   (rd_data),
    .rd_hit    (rd_hit),
    .wr_hit    (wr_hit)
  );

  assign cfg.disable_sw  = mode_config_word[`PMS_BIT_DISABLE];
  assign cfg.sel         = {mode_config_word[`PMS_BIT_SEL_HI],
                            mode_config_word[`PMS_BIT_SEL_LO]};
  assign cfg.ploss_alarm = mode_config_word[`PMS_BIT_PLOSS];

  // Config and threshold; threshold is not rescaled on a type change,
  // software owns that
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      mode_config_word       <= `PMS_CONFIG_RESET;
      switch_threshold_level <= `PMS_LEVEL_RESET;
    end
    else if (wr_en)
    begin
      if (wr_addr == `PMS_OFS_CONFIG)
      begin
        if (wr_strb[0])
          mode_config_word[7:0] <= wr_data[7:0];
        if (wr_strb[1])
          mode_config_word[15:8] <= wr_data[15:8];
      end
      else if (wr_addr == `PMS_OFS_LEVEL)
      begin
        if (wr_strb[0])
          switch_threshold_level[7:0] <= wr_data[7:0];
        if (wr_strb[1])
          switch_threshold_level[15:8] <= wr_data[15:8];
      end
    end
  end

  pms_compare u_cmp
  (
    .sel           (pms_det_type'(cfg.sel)),
    .sample        (sample),
    .position_mode (position_mode),
    .level         (switch_threshold_level),
    .over          (auto_over)
  );

  assign auto_p      = auto_over && !cfg.disable_sw;
  assign next_p_mode = auto_p || !force_proportional_in_n;

  // One decision per control cycle, registered
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      p_mode <= 1'b0;
    else
      p_mode <= next_p_mode;
  end

  // Ready waits a short settle after power returns, filtering glitches
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      power_q    <= 1'b0;
      settle_cnt <= 8'h00;
    end
    else
    begin
      power_q <= main_power_ok;
      if (!main_power_ok)
        settle_cnt <= 8'h00;
      else if (settle_cnt < 8'(`PMS_SETTLE_CYCLES))
        settle_cnt <= settle_cnt + 8'h01;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      servo_ready <= 1'b0;
    else
      servo_ready <= main_power_ok
                     && settle_cnt == 8'(`PMS_SETTLE_CYCLES);
  end

  // Alarm latches on recovery; cleared by writing the config word
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      servo_alarm <= 1'b0;
    else if (main_power_ok && !power_q && cfg.ploss_alarm)
      servo_alarm <= 1'b1;
    else if (wr_en && wr_addr == `PMS_OFS_CONFIG)
      servo_alarm <= 1'b0;
  end

  assign irq_event[`PMS_IRQ_ENTER] = next_p_mode && !p_mode;
  assign irq_event[`PMS_IRQ_LEAVE] = !next_p_mode && p_mode;
  assign irq_event[`PMS_IRQ_PLOSS] = !main_power_ok && power_q;

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      irq_stat <= 3'h0;
      irq_mask <= `PMS_IRQ_MASK_RESET;
    end
    else
    begin
      if (wr_en && wr_addr == `PMS_OFS_IRQ_STAT && wr_strb[0])
        irq_stat <= (irq_stat & ~wr_data[2:0]) | irq_event;
      else
        irq_stat <= irq_stat | irq_event;
      if (wr_en && wr_addr == `PMS_OFS_IRQ_MASK && wr_strb[0])
        irq_mask <= wr_data[2:0];
    end
  end

  assign irq = |(irq_stat & irq_mask);

  assign wr_hit = wr_addr == `PMS_OFS_CONFIG || wr_addr == `PMS_OFS_LEVEL
                  || wr_addr == `PMS_OFS_STATUS
                  || wr_addr == `PMS_OFS_IRQ_STAT
                  || wr_addr == `PMS_OFS_IRQ_MASK;
  assign rd_hit = rd_addr == `PMS_OFS_CONFIG || rd_addr == `PMS_OFS_LEVEL
                  || rd_addr == `PMS_OFS_STATUS
                  || rd_addr == `PMS_OFS_IRQ_STAT
                  || rd_addr == `PMS_OFS_IRQ_MASK;

  always_comb
  begin
    rd_data = 32'h0000_0000;
    if (rd_addr == `PMS_OFS_CONFIG)
      rd_data[15:0] = mode_config_word;
    else if (rd_addr == `PMS_OFS_LEVEL)
      rd_data[15:0] = switch_threshold_level;
    else if (rd_addr == `PMS_OFS_STATUS)
    begin
      rd_data[`PMS_ST_PMODE] = p_mode;
      rd_data[`PMS_ST_AUTO]  = auto_p;
      rd_data[`PMS_ST_READY] = servo_ready;
      rd_data[`PMS_ST_ALARM] = servo_alarm;
    end
    else if (rd_addr == `PMS_OFS_IRQ_STAT)
      rd_data[2:0] = irq_stat;
    else if (rd_addr == `PMS_OFS_IRQ_MASK)
      rd_data[2:0] = irq_mask;
  end

  // Torque at or below level and no force: back to PI
  property p_mode_follows;
    @(posedge mclk) disable iff (rst)
    (force_proportional_in_n && cfg.sel == 2'h0
     && sample.torque <= switch_threshold_level) |=> !p_mode;
  endproperty
  a_mode_follows: assert property (p_mode_follows)
    else $error("p_mode did not follow decision");

  property p_disable_blocks;
    @(posedge mclk) disable iff (rst)
    (cfg.disable_sw && force_proportional_in_n) |=> !p_mode;
  endproperty
  a_disable_blocks: assert property (p_disable_blocks)
    else $error("P mode while switch disabled");

  property p_torque;
    @(posedge mclk) disable iff (rst)
    (!cfg.disable_sw && cfg.sel == 2'h0
     && sample.torque > switch_threshold_level) |=> p_mode;
  endproperty
  a_torque: assert property (p_torque)
    else $error("torque over level without P mode");

  property p_speed;
    @(posedge mclk) disable iff (rst)
    (!cfg.disable_sw && cfg.sel == 2'h1
     && sample.speed > switch_threshold_level) |=> p_mode;
  endproperty
  a_speed: assert property (p_speed)
    else $error("speed over level without P mode");

  property p_accel;
    @(posedge mclk) disable iff (rst)
    (!cfg.disable_sw && cfg.sel == 2'h2
     && sample.accel > switch_threshold_level) |=> p_mode;
  endproperty
  a_accel: assert property (p_accel)
    else $error("accel over level without P mode");

  property p_error_pos;
    @(posedge mclk) disable iff (rst)
    (cfg.sel == 2'h3 && !position_mode && force_proportional_in_n)
    |=> !p_mode;
  endproperty
  a_error_pos: assert property (p_error_pos)
    else $error("error mode acted outside position control");

  property p_ready_off;
    @(posedge mclk) disable iff (rst)
    !main_power_ok |=> !servo_ready;
  endproperty
  a_ready_off: assert property (p_ready_off)
    else $error("ready high without main power");

  sequence s_recover;
    !main_power_ok ##1 main_power_ok;
  endsequence

  property p_alarm;
    @(posedge mclk) disable iff (rst)
    s_recover |-> if (cfg.ploss_alarm) ##1 servo_alarm
                  else ##1 !$rose(servo_alarm);
  endproperty
  a_alarm: assert property (p_alarm)
    else $error("alarm wrong after power recovery");

  property p_force;
    @(posedge mclk) disable iff (rst)
    !force_proportional_in_n |=> p_mode;
  endproperty
  a_force: assert property (p_force)
    else $error("force input ignored");

endmodule : pms_mode_switch

// >>> verilog/pms_map.svh
`ifndef PMS_MAP_SVH
`define PMS_MAP_SVH

// AXI4-Lite register offsets (byte addresses)
`define PMS_OFS_CONFIG     8'h00
`define PMS_OFS_LEVEL      8'h04
`define PMS_OFS_STATUS     8'h08
`define PMS_OFS_IRQ_STAT   8'h0C
`define PMS_OFS_IRQ_MASK   8'h10

// Field positions in mode_config_word
`define PMS_BIT_DISABLE    11
`define PMS_BIT_SEL_LO     12
`define PMS_BIT_SEL_HI     13
`define PMS_BIT_PLOSS      14

// Status bit positions
`define PMS_ST_PMODE       0
`define PMS_ST_AUTO        1
`define PMS_ST_READY       2
`define PMS_ST_ALARM       3

// Interrupt status bit positions
`define PMS_IRQ_ENTER      0
`define PMS_IRQ_LEAVE      1
`define PMS_IRQ_PLOSS      2

// Reset values
`define PMS_CONFIG_RESET   16'h0000
`define PMS_LEVEL_RESET    16'h00C8
`define PMS_IRQ_MASK_RESET 3'h0

// Timing: power must be steady this long before ready rises
`define PMS_POWER_SETTLE_NS 1000
`define PMS_CLK_PERIOD_NS   100
`define PMS_SETTLE_CYCLES \
  ((`PMS_POWER_SETTLE_NS + `PMS_CLK_PERIOD_NS - 1) / `PMS_CLK_PERIOD_NS)

`endif

// >>> verilog/pms_pkg.sv
package pms_pkg;

  typedef enum logic [1:0]
  {
    PMS_DET_TORQUE = 2'h0,
    PMS_DET_SPEED  = 2'h1,
    PMS_DET_ACCEL  = 2'h2,
    PMS_DET_ERROR  = 2'h3
  } pms_det_type;

  typedef struct packed
  {
    logic [15:0] torque;
    logic [15:0] speed;
    logic [15:0] accel;
    logic [15:0] error;
  } pms_sample_type;

  typedef struct packed
  {
    logic        ploss_alarm;
    logic [1:0]  sel;
    logic        disable_sw;
  } pms_cfg_type;

endpackage : pms_pkg

// >>> verilog/pms_axil_slave.sv
`timescale 1ns/1ns
`include "pms_map.svh"

module pms_axil_slave
  import pms_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // AXI4-Lite
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  // Register file side
  output logic             wr_en,
  output logic [7:0]       wr_addr,
  output logic [31:0]      wr_data,
  output logic [3:0]       wr_strb,
  output logic [7:0]       rd_addr,
  input  wire logic [31:0] rd_data,
  input  wire logic        rd_hit,
  input  wire logic        wr_hit
);

  logic       aw_held;
  logic       w_held;
  logic [7:0] aw_addr;

  assign s_awready = !aw_held && !s_bvalid;
  assign s_wready  = !w_held && !s_bvalid;
  assign s_arready = !s_rvalid;
  assign wr_addr   = aw_addr;
  assign rd_addr   = s_araddr;
  assign wr_en     = aw_held && w_held && !s_bvalid;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end
    else if (s_awvalid && s_awready)
    begin
      aw_held <= 1'b1;
      aw_addr <= s_awaddr;
    end
    else if (wr_en)
      aw_held <= 1'b0;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      w_held  <= 1'b0;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
    end
    else if (s_wvalid && s_wready)
    begin
      w_held  <= 1'b1;
      wr_data <= s_wdata;
      wr_strb <= s_wstrb;
    end
    else if (wr_en)
      w_held <= 1'b0;
  end

  // Unmapped write answers SLVERR
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      s_bvalid <= 1'b0;
      s_bresp  <= 2'h0;
    end
    else if (wr_en)
    begin
      s_bvalid <= 1'b1;
      s_bresp  <= wr_hit ? 2'h0 : 2'h2;
    end
    else if (s_bready)
      s_bvalid <= 1'b0;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      s_rvalid <= 1'b0;
      s_rdata  <= 32'h0000_0000;
      s_rresp  <= 2'h0;
    end
    else if (s_arvalid && s_arready)
    begin
      s_rvalid <= 1'b1;
      s_rdata  <= rd_hit ? rd_data : 32'h0000_0000;
      s_rresp  <= rd_hit ? 2'h0 : 2'h2;
    end
    else if (s_rready)
      s_rvalid <= 1'b0;
  end

endmodule : pms_axil_slave

// >>> verilog/pms_compare.sv
`timescale 1ns/1ns

module pms_compare
  import pms_pkg::*;
(
  // Selection and samples
  input  wire pms_det_type    sel,
  input  wire pms_sample_type sample,
  input  wire logic           position_mode,
  input  wire logic [15:0]    level,
  // Result
  output logic                over
);

  // Strictly greater: equal to the level keeps PI control
  always_comb
  begin
    unique case (sel)
      PMS_DET_TORQUE: over = sample.torque > level;
      PMS_DET_SPEED:  over = sample.speed > level;
      PMS_DET_ACCEL:  over = sample.accel > level;
      PMS_DET_ERROR:  over = position_mode
                             && (sample.error > level);
    endcase
  end

endmodule : pms_compare

// >>> test/pms_far_end.sv
`timescale 1ns/1ns

// Command and feedback sources plus a speed regulator that counts P cycles
module pms_far_end
  import pms_pkg::*;
(
  // Clock and reset
  input  wire logic           mclk,
  input  wire logic           rst,
  // Settings from the bench
  input  wire pms_sample_type want_sample,
  input  wire logic           want_pos,
  input  wire logic           want_force_n,
  input  wire logic           want_power,
  // Toward the block
  output pms_sample_type      sample,
  output logic                position_mode,
  output logic                force_proportional_in_n,
  output logic                main_power_ok,
  // Regulator side
  input  wire logic           p_mode,
  output logic [15:0]         p_cycles
);
  // New samples once per control cycle, like a real loop update
  always_ff @(posedge mclk)
  begin
    sample                  <= want_sample;
    position_mode           <= want_pos;
    force_proportional_in_n <= want_force_n;
    main_power_ok           <= want_power;
  end

  // Integrator frozen while P-only; only the cycle count is modelled
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      p_cycles <= 16'h0000;
    else if (p_mode)
      p_cycles <= p_cycles + 16'h0001;
  end
endmodule : pms_far_end

// >>> test/testbench.sv
`timescale 1ns/1ns

module testbench
  import pms_pkg::*;
;
  logic mclk, rst;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, rr;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  pms_sample_type want_sample, sample;
  logic want_pos, want_force_n, want_power;
  logic position_mode, force_n, power_ok;
  logic p_mode, servo_ready, servo_alarm, irq, irq_a;
  logic [15:0] p_cycles;
  int err_count, compares;

  pms_mode_switch DUT (.mclk(mclk), .rst(rst),
    .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready),
    .s_wdata(wdata), .s_wstrb(4'hF), .s_wvalid(wvalid), .s_wready(wready),
    .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
    .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready),
    .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready),
    .sample(sample), .position_mode(position_mode),
    .force_proportional_in_n(force_n), .main_power_ok(power_ok),
    .p_mode(p_mode), .servo_ready(servo_ready),
    .servo_alarm(servo_alarm), .irq(irq));

  pms_far_end far (.mclk(mclk), .rst(rst), .want_sample(want_sample),
    .want_pos(want_pos), .want_force_n(want_force_n),
    .want_power(want_power), .sample(sample),
    .position_mode(position_mode), .force_proportional_in_n(force_n),
    .main_power_ok(power_ok), .p_mode(p_mode), .p_cycles(p_cycles));

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task chk(input string name, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task conclude;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  // Bus write; both channels offered together, bready held until bvalid
  task axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    rr = bresp;
    bready <= 1'b0;
  endtask : axw

  task axr(input logic [7:0] a);
    @(posedge mclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rd = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask : axr

  // Selected field gets v, the other three get o
  task put(input logic [1:0] sel, input logic [15:0] v, o);
    pms_sample_type s;
    s = {o, o, o, o};
    s[(3 - sel) * 16 +: 16] = v;
    want_sample <= s;
    repeat (4) @(posedge mclk);
  endtask : put

  initial
  begin
    #300000;
    err_count++;
    conclude();
  end

  initial
  begin
    err_count = 0;
    compares = 0;
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h00000000;
    want_sample = '0;
    want_pos = 1'b1;
    want_force_n = 1'b1;
    want_power = 1'b1;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    axr(8'h00);
    chk("config", rd, 32'h00000000);
    axr(8'h04);
    chk("level", rd, 32'h000000C8);
    axr(8'h10);
    chk("mask", rd, 32'h00000000);
    axr(8'h20);
    chk("unmapped resp", {30'h0, rr}, 32'h00000002);
    axw(8'h20, 32'h00000001);
    chk("unmapped wr resp", {30'h0, rr}, 32'h00000002);
    put(2'h0, 16'h00C9, 16'h0000);
    chk("p torque 201", p_mode, 1'b1);
    put(2'h0, 16'h00C8, 16'h0000);
    chk("p torque 200", p_mode, 1'b0);
    for (int m = 0; m < 4; m++)
    begin
      axw(8'h00, 32'(m) << 12);
      axw(8'h04, 32'h00000064);
      chk("level resp", {30'h0, rr}, 32'h00000000);
      put(m[1:0], 16'h0065, 16'h0000);
      chk("p over", p_mode, 1'b1);
      axr(8'h08);
      chk("status p", rd[0], 1'b1);
      put(m[1:0], 16'h0064, 16'h01F4);
      chk("p at level", p_mode, 1'b0);
    end
    put(2'h3, 16'h0065, 16'h0000);
    chk("p error", p_mode, 1'b1);
    want_pos <= 1'b0;
    put(2'h3, 16'h0065, 16'h0000);
    chk("p not position", p_mode, 1'b0);
    want_pos <= 1'b1;
    axw(8'h00, 32'h00003800);
    put(2'h3, 16'h0065, 16'h0000);
    chk("p disabled", p_mode, 1'b0);
    want_force_n <= 1'b0;
    put(2'h3, 16'h0000, 16'h0000);
    chk("p forced", p_mode, 1'b1);
    rd = {16'h0000, p_cycles};
    repeat (4) @(posedge mclk);
    chk("p cycles", 16'(p_cycles - rd[15:0]), 32'h00000004);
    want_force_n <= 1'b1;
    axw(8'h00, 32'h00004000);
    put(2'h0, 16'h0000, 16'h0000);
    chk("p released", p_mode, 1'b0);
    chk("ready on", servo_ready, 1'b1);
    want_power <= 1'b0;
    repeat (5) @(posedge mclk);
    chk("ready off", servo_ready, 1'b0);
    want_power <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("ready settling", servo_ready, 1'b0);
    repeat (20) @(posedge mclk);
    chk("ready back", servo_ready, 1'b1);
    chk("alarm", servo_alarm, 1'b1);
    axr(8'h0C);
    chk("irq lost", rd[2], 1'b1);
    irq_a = irq;
    axw(8'h10, 32'h00000007);
    repeat (2) @(posedge mclk);
    chk("irq masked", irq_a, 1'b0);
    chk("irq unmasked", irq, 1'b1);
    axw(8'h0C, 32'h00000007);
    axr(8'h0C);
    chk("irq cleared", rd, 32'h00000000);
    chk("irq low", irq, 1'b0);
    axw(8'h00, 32'h00000000);
    want_power <= 1'b0;
    repeat (5) @(posedge mclk);
    want_power <= 1'b1;
    repeat (25) @(posedge mclk);
    chk("no alarm", servo_alarm, 1'b0);
    conclude();
  end
endmodule : testbench
